// ==== rtl/r2w_target.sv ====
// Contract
// - One data bit per clock pulse
// - Transmitter changes data only while clock low
// - Receiver samples data while clock high
// - Idle bus: both lines released high
// - Data falling, clock high: start
// - Data rising, clock high: stop
// - Own address is 1010 001
// - Respond only on matching address
// - First byte: address bits 7..1, flag bit0
// - Unlimited bytes between start and stop
// - Ninth pulse: receiver pulls data low
// - Release data after acknowledge pulse
// - Master nack ends read; device releases
// - Device is target only, never clocks
// - Write: address, word address, data, stop
// - Store data at pointer, then increment
// - Random read via repeated start
// - Read address acked: device transmits
// - Pointer advances after each sent byte
// - Plain read starts at last plus one
// - Lines only pulled low or released

// ==========================================================================
// Two-wire target port of the clock module
module r2w_target import r2w_pkg::*; (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Serial clock pin, input only
  input  wire logic       scl_i,
  // Serial data pin, open drain
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Register file side
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_we,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);

  // ==========================================================================
  // State
  typedef struct packed {
    r2w_state_t state;    // Protocol state
    r2w_phase_t phase;    // Byte role inside a frame
    logic [3:0] bitcnt;   // Bits moved in current byte
    logic [7:0] shreg;    // Shift register
    logic [3:0] ptr;      // Register pointer
    logic [3:0] acc_addr; // Address shown to register file
    logic [7:0] wdata;    // Write data to register file
    logic       we;       // Write strobe
    logic       rd;       // Read strobe
    logic       rw;       // Frame direction flag
    logic       mack;     // Master acknowledge level
    logic       oe;       // Data pin pulled low
    logic       sda_drv;  // Data pin output level
    logic       scl_prev; // Clock level last cycle
    logic       sda_prev; // Data level last cycle
  } r2w_regs_t;

  // Reset image of the state
  localparam r2w_regs_t R2W_REGS_RESET = '{
    state:    ST_IDLE,
    phase:    PH_ADDR,
    bitcnt:   4'h0,
    shreg:    R2W_DATA_RESET,
    ptr:      R2W_PTR_RESET,
    acc_addr: R2W_PTR_RESET,
    wdata:    R2W_DATA_RESET,
    we:       1'b0,
    rd:       1'b0,
    rw:       1'b0,
    mack:     1'b1,
    oe:       1'b0,
    sda_drv:  1'b0,
    scl_prev: 1'b1,
    sda_prev: 1'b1
  };

  r2w_regs_t  q;       // Current state
  r2w_regs_t  next_q;  // Next state
  logic [1:0] pins;    // Filtered clock and data
  logic       scl;     // Filtered clock
  logic       sda;     // Filtered data
  logic       rise;    // Clock rising edge
  logic       fall;    // Clock falling edge
  logic       start;   // Start or repeated start
  logic       stop;    // Stop condition

  // Pointer increment with wrap
  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = (p == R2W_PTR_MAX) ? R2W_PTR_RESET : p + 4'h1;
  endfunction

  // ==========================================================================
  // Pin sampling
  r2w_sync #(
    .WIDTH (2),
    .INIT  (2'h3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .async_in ({scl_i, sda_i}),
    .level    (pins)
  );

  assign scl = pins[1];
  assign sda = pins[0];

  // Clock edges and bus conditions
  assign rise  = scl & ~q.scl_prev;
  assign fall  = ~scl & q.scl_prev;
  assign start = scl & q.scl_prev & q.sda_prev & ~sda;
  assign stop  = scl & q.scl_prev & ~q.sda_prev & sda;

  // ==========================================================================
  // Next state
  always_comb begin
    next_q          = q;
    next_q.we       = 1'b0;
    next_q.rd       = 1'b0;
    next_q.sda_drv  = 1'b0;  // Only ever pull low
    next_q.scl_prev = scl;
    next_q.sda_prev = sda;
    next_q.acc_addr = q.ptr; // Lags pointer by one cycle

    if (stop) begin
      // Stop ends any frame and frees the line
      next_q.state = ST_IDLE;
      next_q.oe    = 1'b0;
    end else if (start) begin
      // Start, also repeated start, expects an address
      next_q.state  = ST_RX;
      next_q.phase  = PH_ADDR;
      next_q.bitcnt = 4'h0;
      next_q.oe     = 1'b0;
    end else begin
      case (q.state)
        // Released, waiting for start
        ST_IDLE: begin
          next_q.oe = 1'b0;
        end

        // Receive a byte
        ST_RX: begin
          if (rise && q.bitcnt < R2W_BYTE_BITS) begin
            // One bit per pulse, sampled while high
            next_q.shreg  = {q.shreg[6:0], sda};
            next_q.bitcnt = q.bitcnt + 4'h1;
          end else if (fall && q.bitcnt == R2W_BYTE_BITS) begin
            next_q.bitcnt = 4'h0;
            case (q.phase)
              // Address byte
              PH_ADDR: begin
                if (q.shreg[7:1] == R2W_OWN_ADDR) begin
                  next_q.rw    = q.shreg[R2W_RW_BIT];
                  next_q.oe    = 1'b1;
                  next_q.state = ST_RX_ACK;
                end else begin
                  next_q.state = ST_IDLE;
                end
              end
              // Word address byte
              PH_WORD: begin
                next_q.ptr   = q.shreg[3:0];
                next_q.oe    = 1'b1;
                next_q.state = ST_RX_ACK;
              end
              // Data byte, stored then pointer steps
              default: begin
                next_q.wdata = q.shreg;
                next_q.we    = 1'b1;
                next_q.ptr   = ptr_inc(q.ptr);
                next_q.oe    = 1'b1;
                next_q.state = ST_RX_ACK;
              end
            endcase
          end
        end

        // Hold acknowledge through the ninth pulse
        ST_RX_ACK: begin
          if (fall) begin
            next_q.oe = 1'b0;
            if (q.phase == PH_ADDR && q.rw) begin
              // Become transmitter, first bit out
              next_q.shreg  = reg_rdata;
              next_q.rd     = 1'b1;
              next_q.oe     = ~reg_rdata[7];
              next_q.bitcnt = 4'h0;
              next_q.state  = ST_TX;
            end else begin
              // Next byte of a write frame
              next_q.phase  = (q.phase == PH_ADDR) ? PH_WORD : PH_DATA;
              next_q.bitcnt = 4'h0;
              next_q.state  = ST_RX;
            end
          end
        end

        // Shift a byte out, changing only after a fall
        ST_TX: begin
          if (fall) begin
            next_q.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt + 4'h1 == R2W_BYTE_BITS) begin
              next_q.oe    = 1'b0;
              next_q.ptr   = ptr_inc(q.ptr);
              next_q.state = ST_TX_ACK;
            end else begin
              next_q.shreg = {q.shreg[6:0], 1'b0};
              next_q.oe    = ~q.shreg[6];
            end
          end
        end

        // Master acknowledge decides continuation
        ST_TX_ACK: begin
          if (rise) begin
            next_q.mack = sda;
          end else if (fall) begin
            if (!q.mack) begin
              // Low acknowledge: send next register
              next_q.shreg  = reg_rdata;
              next_q.rd     = 1'b1;
              next_q.oe     = ~reg_rdata[7];
              next_q.bitcnt = 4'h0;
              next_q.state  = ST_TX;
            end else begin
              // High acknowledge: stay off the line
              next_q.oe    = 1'b0;
              next_q.state = ST_IDLE;
            end
          end
        end

        default: begin
          next_q.state = ST_IDLE;
        end
      endcase
    end
  end

  // Register the state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= R2W_REGS_RESET;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops; no clock pin is driven
  assign sda_o     = q.sda_drv;
  assign sda_oe    = q.oe;
  assign reg_addr  = q.acc_addr;
  assign reg_wdata = q.wdata;
  assign reg_we    = q.we;
  assign reg_rd    = q.rd;

  // ==========================================================================
  // Assertions
  default clocking r2w_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // Data drive changes only right after a clock fall or a bus condition
  a_drive_on_low: assert property ($changed(q.oe) |-> $past(fall) || $past(start) || $past(stop))
    else $error("data drive changed outside clock low");

  // Foreign address leaves the line alone
  a_foreign_silent: assert property (
    (q.state == ST_RX && q.phase == PH_ADDR && fall && q.bitcnt == R2W_BYTE_BITS && !start && !stop
     && q.shreg[7:1] != R2W_OWN_ADDR) |=> (q.state == ST_IDLE && !q.oe)[*2])
    else $error("answered a foreign address");

  // Own address is acknowledged during the ninth pulse
  a_own_ack: assert property (
    (q.state == ST_RX && q.phase == PH_ADDR && fall && q.bitcnt == R2W_BYTE_BITS && !start && !stop
     && q.shreg[7:1] == R2W_OWN_ADDR) |=> q.oe && q.state == ST_RX_ACK)
    else $error("own address not acknowledged");

  // Stop always frees the line
  a_stop_frees: assert property (stop |=> q.state == ST_IDLE && !q.oe)
    else $error("stop did not free the line");

  // Start restarts address reception
  a_start_addr: assert property (start |=> q.state == ST_RX && q.phase == PH_ADDR && q.bitcnt == 4'h0)
    else $error("start did not restart addressing");

  // Idle never pulls the line
  a_idle_release: assert property (q.state == ST_IDLE && $past(q.state) == ST_IDLE |-> !q.oe)
    else $error("idle device pulls data");

  // Each write lands at the old pointer and steps it with wrap
  a_write_step: assert property (q.we |-> q.ptr == ptr_inc(q.acc_addr) && !$past(q.we))
    else $error("write pointer step wrong");

  // Pointer steps after each byte sent
  a_read_step: assert property (
    (q.state == ST_TX && fall && q.bitcnt == 4'h7 && !start && !stop) |=> q.ptr == ptr_inc($past(q.ptr)))
    else $error("read pointer did not advance");

  // Master nack ends reading with the line released
  a_nack_end: assert property (
    (q.state == ST_TX_ACK && fall && q.mack && !start && !stop) |=> !q.oe && q.state == ST_IDLE)
    else $error("device kept driving after nack");

  // Scenarios of interest
  c_write_byte: cover property (q.we);
  c_read_byte:  cover property (q.rd && $past(q.state) == ST_RX_ACK);
  c_read_more:  cover property (q.rd && $past(q.state) == ST_TX_ACK);
  c_wrap:       cover property (q.ptr == R2W_PTR_RESET && $past(q.ptr) == R2W_PTR_MAX);

endmodule // r2w_target

// ==== rtl/r2w_pkg.sv ====
// ==========================================================================
// Shared constants and types of the two-wire target port
package r2w_pkg;

  // ==========================================================================
  // Addressing
  localparam logic [6:0] R2W_OWN_ADDR  = 7'h51;  // Target address 1010 001
  localparam int         R2W_RW_BIT    = 0;      // Read/write flag position
  localparam logic [3:0] R2W_PTR_MAX   = 4'hf;   // Highest register index
  localparam logic [3:0] R2W_PTR_RESET = 4'h0;   // Pointer after reset

  // ==========================================================================
  // Byte framing
  localparam logic [3:0] R2W_BYTE_BITS = 4'h8;   // Data bits per byte
  localparam logic [7:0] R2W_DATA_RESET = 8'h00; // Data registers at reset

  // ==========================================================================
  // Protocol states
  typedef enum logic [2:0] {
    ST_IDLE,    // Not addressed, lines released
    ST_RX,      // Shifting a byte in from the master
    ST_RX_ACK,  // Driving our acknowledge
    ST_TX,      // Shifting a byte out to the master
    ST_TX_ACK   // Sampling the master's acknowledge
  } r2w_state_t;

  // Which byte of a write frame is being received
  typedef enum logic [1:0] {
    PH_ADDR,    // Target address plus read/write flag
    PH_WORD,    // Register pointer
    PH_DATA     // Payload bytes
  } r2w_phase_t;

endpackage : r2w_pkg

// ==== rtl/r2w_sync.sv ====
// ==========================================================================
// Three-stage pin synchroniser with agreement filter
module r2w_sync import r2w_pkg::*; #(
  parameter int               WIDTH = 2,          // Number of pins
  parameter logic [WIDTH-1:0] INIT  = '1          // Level during reset
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Raw pins
  input  wire logic [WIDTH-1:0] async_in,
  // Filtered levels
  output logic      [WIDTH-1:0] level
);

  // All state of the synchroniser
  typedef struct packed {
    logic [WIDTH-1:0] s1;   // First stage, read only by s2
    logic [WIDTH-1:0] s2;   // Second stage
    logic [WIDTH-1:0] s3;   // Third stage
    logic [WIDTH-1:0] lvl;  // Accepted level
  } r2w_sync_t;

  r2w_sync_t q;     // Current state
  r2w_sync_t next_q; // Next state

  // ==========================================================================
  // Next state: a change counts once stages two and three agree
  always_comb begin
    next_q    = q;
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      // Accept only a settled value
      if (q.s2[i] == q.s3[i]) begin
        next_q.lvl[i] = q.s3[i];
      end
    end
  end

  // Register the state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
    end else begin
      q <= next_q;
    end
  end

  assign level = q.lvl;

endmodule // r2w_sync

// ==== tb/r2w_master.sv ====
// ==========================================================================
// Two-wire bus master model, drives clock and pulls data low
module r2w_master (
  // Bench clock, paces the quarter bit
  input  wire logic ref_clk,
  // Bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // Lines released while idle
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter of a 48 ns bit, moved just after a clock edge
  task automatic q();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  // Start or repeated start: data falls with clock high
  task automatic start_c();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask

  // Stop: data rises with clock high
  task automatic stop_c();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask

  // One clock pulse, one bit each way
  task automatic clk_bit(input logic b, output logic s);
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
    q();
  endtask

  // Byte out, MSB first, then sample the acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, ack);
  endtask

  // Byte in, then our acknowledge: low continues, high ends
  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(ack, s);
  endtask
endmodule  // r2w_master

// ==== tb/r2w_target_tb.sv ====
// ==========================================================================
// Self-checking bench of the two-wire target port
module r2w_target_tb import r2w_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic       ref_clk;       // 250 MHz clock
  logic       rst_b;         // Reset, active low
  logic       scl;           // Serial clock from master
  logic       m_low;         // Master pulls data low
  logic       sda_i;         // Resolved data wire
  logic       sda_o;         // Device data value
  logic       sda_oe;        // Device pulls data
  logic [3:0] reg_addr;      // Register index
  logic [7:0] reg_wdata;     // Write data
  logic       reg_we;        // Write strobe
  logic       reg_rd;        // Read strobe
  logic [7:0] reg_rdata;     // Read data
  logic [7:0] regs [16];     // Register file model
  logic [7:0] exp_r [16];    // Expected register contents
  int         fails;         // Mismatches
  int         n_checks;      // Comparisons
  int         we_cnt;        // Write strobes seen
  int         rd_cnt;        // Read strobes seen

  // ==========================================================================
  // Clock, wire and register file
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Wired-AND with pull-up
  assign sda_i     = ~(m_low | (sda_oe & ~sda_o));
  assign reg_rdata = regs[reg_addr];
  // Store strobed writes, count read strobes
  always @(posedge ref_clk) begin
    if (reg_we) begin
      regs[reg_addr] <= reg_wdata;
      we_cnt         <= we_cnt + 1;
    end
    if (reg_rd) begin
      rd_cnt <= rd_cnt + 1;
    end
  end

  r2w_master u_mst (
    .ref_clk (ref_clk),
    .scl     (scl),
    .sda_low (m_low),
    .sda     (sda_i)
  );

  r2w_target u_dut (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .scl_i     (scl),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe    (sda_oe),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_we    (reg_we),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );

  // ==========================================================================
  // Compare and report
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // Read with no word address from the given index
  task automatic sc_cur_read(input logic [3:0] idx);
    logic       a;
    logic [7:0] d;
    int         r0;
    r0 = rd_cnt;
    u_mst.start_c();
    u_mst.put({R2W_OWN_ADDR, 1'b1}, a);
    chk("cur ack", a, 8'h00);
    u_mst.get(1'b1, d);
    chk("cur data", d, exp_r[idx]);
    // Give a device that wrongly goes on sending time to pull data
    u_mst.q();
    chk("cur nack release", sda_oe, 8'h00);
    u_mst.stop_c();
    chk("cur release", sda_oe, 8'h00);
    chk("cur rd strobes", 8'(rd_cnt - r0), 8'h01);
  endtask

  // Write three bytes from 0e, wrapping to 00
  task automatic sc_write();
    logic       a;
    logic [7:0] dat [3] = '{8'ha5, 8'h3c, 8'h81};
    u_mst.start_c();
    u_mst.put({R2W_OWN_ADDR, 1'b0}, a);
    chk("wr addr ack", a, 8'h00);
    u_mst.put(8'h0e, a);
    chk("wr word ack", a, 8'h00);
    for (int i = 0; i < 3; i++) begin
      u_mst.put(dat[i], a);
      chk("wr data ack", a, 8'h00);
      exp_r[4'(14 + i)] = dat[i];
    end
    u_mst.stop_c();
    for (int i = 0; i < 3; i++) begin
      chk("wr store", regs[4'(14 + i)], exp_r[4'(14 + i)]);
    end
  endtask

  // Random read of three bytes from 0e through repeated start
  task automatic sc_rand_read();
    logic       a;
    logic [7:0] d;
    int         r0;
    r0 = rd_cnt;
    u_mst.start_c();
    u_mst.put({R2W_OWN_ADDR, 1'b0}, a);
    chk("rd addr ack", a, 8'h00);
    u_mst.put(8'h0e, a);
    chk("rd word ack", a, 8'h00);
    u_mst.start_c();
    u_mst.put({R2W_OWN_ADDR, 1'b1}, a);
    chk("rd ack", a, 8'h00);
    for (int i = 0; i < 3; i++) begin
      u_mst.get(i == 2, d);
      chk("rd data", d, exp_r[4'(14 + i)]);
    end
    // Give a device that wrongly goes on sending time to pull data
    u_mst.q();
    chk("rd nack release", sda_oe, 8'h00);
    u_mst.stop_c();
    chk("rd release", sda_oe, 8'h00);
    chk("rd strobes", 8'(rd_cnt - r0), 8'h03);
  endtask

  // Every single-bit miss of the address stays silent
  task automatic sc_bad_addr();
    logic a;
    int   w0;
    w0 = we_cnt;
    for (int i = 0; i < 7; i++) begin
      u_mst.start_c();
      u_mst.put({R2W_OWN_ADDR ^ 7'(1 << i), 1'b0}, a);
      chk("bad addr ack", a, 8'h01);
      u_mst.put(8'h00, a);
      chk("bad word ack", a, 8'h01);
      u_mst.stop_c();
    end
    chk("bad no write", 8'(we_cnt - w0), 8'h00);
  endtask

  // Word f5 loads 5, then a half byte is cut off by stop
  task automatic sc_abort();
    logic a;
    int   w0;
    w0 = we_cnt;
    u_mst.start_c();
    u_mst.put({R2W_OWN_ADDR, 1'b0}, a);
    u_mst.put(8'hf5, a);
    for (int i = 0; i < 4; i++) begin
      u_mst.clk_bit(1'b0, a);
    end
    u_mst.stop_c();
    chk("abort no write", 8'(we_cnt - w0), 8'h00);
    chk("abort reg", regs[5], exp_r[5]);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_b    = 1'b0;
    fails    = 0;
    n_checks = 0;
    we_cnt   = 0;
    rd_cnt   = 0;
    for (int i = 0; i < 16; i++) begin
      regs[i]  = 8'h40 + 8'(i);
      exp_r[i] = 8'h40 + 8'(i);
    end
    repeat (6) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    chk("reset oe", sda_oe, 8'h00);
    chk("reset we", reg_we, 8'h00);
    chk("reset rd", reg_rd, 8'h00);
    repeat (4) @(posedge ref_clk);
    sc_cur_read(4'h0);
    sc_write();
    sc_rand_read();
    sc_cur_read(4'h1);
    sc_bad_addr();
    sc_abort();
    sc_cur_read(4'h5);
    end_sim();
  end

  // Hang guard
  initial begin
    #200000;
    fails++;
    end_sim();
  end
endmodule  // r2w_target_tb
